//--- bench/pfs_host.sv
// host model: issues single-byte register commands to the status block
// assumes the bench calls wr/rd just after a rising edge
`timescale 1ns/1ps
module pfs_host (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out,
  output logic            rd_out,
  output logic            cor_out
);
  // idle bus at time zero
  initial
  begin
    addr_out  = 8'h00;
    wr_out    = 1'b0;
    wdata_out = 8'h00;
    rd_out    = 1'b0;
    cor_out   = 1'b0;
  end
  // one write strobe, held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in); // idle edge keeps two strobes apart
    #1 addr_out = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(posedge sys_clk_in);
    #1 wr_out = 1'b0;
    wdata_out = ~d; // stale data never looks valid
  endtask
  // one read; data is registered, so taken after the sampling edge
  task automatic rd(input logic [7:0] a, input logic c,
                    output logic [7:0] q);
    @(posedge sys_clk_in); // idle edge keeps two strobes apart
    #1 addr_out = a;
    cor_out  = c;
    rd_out   = 1'b1;
    @(posedge sys_clk_in);
    #1 rd_out = 1'b0;
    cor_out  = 1'b0;
    q        = rdata_in;
  endtask
endmodule // pfs_host

//--- bench/pfs_status_bench.sv
// self-checking bench for the status and safe-mode block
// assumes pfs_pkg compiled first; host model drives the register port
`timescale 1ns/1ps
module pfs_status_bench;
  import pfs_pkg::*;
  logic clk, rst_b, pin_b, fs, wr, rd, cor, thermal_shutdown_flag, digital_supply_undervoltage_flag, digital_supply_warning_flag, power_supply_undervoltage_flag;
  logic ab30, lock, merr, ilim;
  logic [7:0] addr, wd, rdat, pwr, on, foff, q, d;
  logic [2:0] code;
  logic [3:0] cdone, ddone, cut, cutoff;
  logic [11:0] ccode, dcode;
  logic [2:0] coff;
  logic safe, run;
  int n_errors, num_checks, cyc;
  int disc[3]; // model of the discovery bytes
  pfs_host host (.sys_clk_in(clk), .rdata_in(rdat), .addr_out(addr),
    .wr_out(wr), .wdata_out(wd), .rd_out(rd), .cor_out(cor));
  pfs_status dut (.sys_clk_in(clk), .rst_b_in(rst_b),
    .reset_pin_b_in(pin_b), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_rd_in(rd), .reg_cor_in(cor),
    .reg_rdata_out(rdat), .fast_shutdown_pin_in(fs),
    .priority_code_in(code), .tsd_cond_in(thermal_shutdown_flag), .digital_supply_undervoltage_flag_cond_in(digital_supply_undervoltage_flag),
    .digital_supply_warning_flag_cond_in(digital_supply_warning_flag), .power_supply_undervoltage_flag_cond_in(power_supply_undervoltage_flag),
    .vpwr_above_30_in(ab30), .vpwr_lockout_in(lock),
    .mem_error_in(merr), .ch_powered_in(pwr), .class_done_in(cdone),
    .det_done_in(ddone), .class_code_in(ccode), .det_code_in(dcode),
    .ch_off_in(coff), .cut_over_in(cut), .ilim_event_in(ilim),
    .power_on_out(on), .ch_force_off_out(foff),
    .port_cut_off_out(cutoff), .safe_mode_out(safe),
    .mem_run_en_out(run));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles used
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // step n cycles, landing just after an edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_b, fs, thermal_shutdown_flag, digital_supply_undervoltage_flag, digital_supply_warning_flag, power_supply_undervoltage_flag, ab30, lock, merr, ilim} = '0;
    {ccode, dcode, pwr, code, cdone, ddone, coff, cut} = '0;
    pin_b = 1'b1;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(32'hda50));
    step(5);
    rst_b = 1'b1;
    // reset values and read-only discovery bytes
    for (int i = 0; i < 3; i++)
    begin
      disc[i] = 0;
      host.wr(ADDR_DISC1 + 8'(i), 8'hff);
      host.rd(ADDR_DISC1 + 8'(i), 1'b0, q);
      chk("disc_rst", 8'(disc[i]), q);
    end
    host.rd(ADDR_FW_REV, 1'b0, q);
    chk("fw_rev", FW_REV_VAL, q);
    $display("test reset done");
    // discovery capture per channel, then clear on turn-off
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      ccode[4*i +: 4] = d[7:4];
      dcode[4*i +: 4] = d[3:0];
      cdone[i] = 1'b1;
      ddone[i] = 1'b1;
      disc[i] = d;
      step(1);
      {cdone, ddone} = '0;
      host.rd(ADDR_DISC1 + 8'(i), 1'b0, q);
      chk("disc_val", 8'(disc[i]), q);
      coff[i] = 1'b1;
      step(1);
      coff = '0;
      disc[i] = 0;
      host.rd(ADDR_DISC1 + 8'(i), 1'b0, q);
      chk("disc_off", 8'(disc[i]), q);
    end
    $display("test discovery done");
    // power-on pulses, refused under supply undervoltage
    d = 8'($urandom) | 8'h01;
    host.wr(ADDR_PWR_ON, d);
    chk("pwr_on", d, on);
    power_supply_undervoltage_flag = 1'b1;
    digital_supply_undervoltage_flag = 1'b1;
    step(8);
    host.wr(ADDR_PWR_ON, d);
    chk("pwr_uv", 8'h00, on);
    host.rd(ADDR_SUP_EVT, 1'b1, q);
    host.rd(ADDR_SUP_EVT, 1'b0, q);
    chk("uv_keep", 8'h50, q & 8'h50);
    ab30 = 1'b1;
    step(8);
    host.wr(ADDR_PWR_ON, d);
    chk("pwr_30v", d, on);
    $display("test undervoltage done");
    // thermal flag survives the reset pin
    thermal_shutdown_flag = 1'b1;
    step(8);
    thermal_shutdown_flag = 1'b0;
    pin_b = 1'b0;
    step(8);
    pin_b = 1'b1;
    step(8);
    host.rd(ADDR_SUP_EVT, 1'b0, q);
    chk("tsd_keep", 8'hd0, q & 8'hd0);
    $display("test reset pin done");
    // single-bit then three-bit shutdown modes
    host.wr(ADDR_FS_EN, 8'h01);
    fs = 1'b1;
    step(8);
    host.rd(ADDR_FLT_EVT, 1'b1, q);
    chk("shdn_1bit", 8'h02, q & 8'h02);
    fs = 1'b0;
    host.wr(ADDR_PRIO_CFG, 8'h80);
    host.wr(ADDR_PRIO_LO, 8'h03);
    step(8);
    host.rd(ADDR_FLT_EVT, 1'b1, q);
    code = 3'h2;
    fs = 1'b1;
    step(8);
    host.rd(ADDR_FLT_EVT, 1'b1, q);
    chk("shdn_low", 8'h00, q & 8'h02);
    code = 3'h3;
    step(8);
    host.rd(ADDR_FLT_EVT, 1'b0, q);
    chk("shdn_3bit", 8'h02, q & 8'h02);
    fs = 1'b0;
    $display("test shutdown done");
    // summed cut: port 0 protection off, port 1 on
    ilim = 1'b1;
    step(3);
    ilim = 1'b0;
    host.wr(ADDR_CUT_EN, 8'h02);
    cut = 4'h3;
    step(OVLD_CYC - 1);
    chk("cut_early", 8'h00, 8'(cutoff));
    step(1);
    chk("cut_off", 8'h02, 8'(cutoff));
    host.rd(ADDR_FLT_EVT, 1'b1, q);
    cut = 4'h0;
    chk("cut_flt", 8'h30, q & 8'hf0);
    host.rd(ADDR_FLT_EVT, 1'b0, q);
    chk("cut_cor", 8'h00, q & 8'hf0);
    host.rd(ADDR_CURRENT_LIMIT_FAULT_COUNTER, 1'b0, q);
    chk("current_limit_fault_counter_keep", 8'h03, q);
    $display("test cut done");
    // detection events kept under undervoltage, lost at lockout
    cdone = 4'h5;
    ddone = 4'ha;
    step(1);
    {cdone, ddone} = '0;
    host.rd(ADDR_DET_EVT, 1'b0, q);
    chk("evt_uv", 8'h5a, q);
    lock = 1'b1;
    step(8);
    lock = 1'b0;
    step(8);
    host.rd(ADDR_DET_EVT, 1'b0, q);
    chk("evt_lock", 8'h00, q);
    $display("test events done");
    // memory fault: ignored until parity monitoring is armed
    merr = 1'b1;
    step(1);
    merr = 1'b0;
    step(1);
    chk("no_mon", 8'h00, 8'(safe));
    host.wr(ADDR_MEM_CTL, 8'h07);
    chk("run_en", 8'h01, 8'(run));
    pwr = 8'h0f;
    merr = 1'b1;
    step(1);
    merr = 1'b0;
    for (int i = 0; i < 8 && safe !== 1'b1; i++) step(1);
    chk("safe", 8'h01, 8'(safe));
    chk("run_clr", 8'h00, 8'(run));
    chk("force_off", 8'hf0, foff);
    host.rd(ADDR_FW_REV, 1'b0, q);
    chk("fw_safe", SAFE_FW_REV, q);
    host.wr(ADDR_MEM_CTL, 8'h07);
    step(2);
    chk("safe_exit", 8'h00, 8'(safe));
    host.rd(ADDR_SUP_EVT, 1'b0, q);
    chk("memflt", 8'h01, q & 8'h01);
    host.rd(ADDR_SUP_EVT, 1'b1, q);
    host.rd(ADDR_SUP_EVT, 1'b0, q);
    chk("memflt_cor", 8'h00, q & 8'h01);
    $display("test safe mode done");
    results();
  end
endmodule // pfs_status_bench

//--- rtl/pfs_pkg.sv
// package: register map, field positions, reset values, timing
// assumes a 250 MHz device clock and 8-bit register data
package pfs_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;    // 250 MHz device clock
  localparam int OVLD_TIME_NS  = 1000; // overload timeout, plain default
  // least time, so round up to whole cycles
  localparam int OVLD_CYC =
    (OVLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register command codes
  localparam logic [7:0] ADDR_DET_EVT  = 8'h04; // class/detect events
  localparam logic [7:0] ADDR_FLT_EVT  = 8'h06; // cut and shutdown events
  localparam logic [7:0] ADDR_SUP_EVT  = 8'h0a; // supply and fault events
  localparam logic [7:0] ADDR_DISC1    = 8'h0c; // channel_one_discovery
  localparam logic [7:0] ADDR_DISC2    = 8'h0d; // channel_two_discovery
  localparam logic [7:0] ADDR_DISC3    = 8'h0e; // channel_three_discovery
  localparam logic [7:0] ADDR_PRIO_CFG = 8'h17; // priority mode select
  localparam logic [7:0] ADDR_PWR_ON   = 8'h19; // power-on commands
  localparam logic [7:0] ADDR_FS_EN    = 8'h1b; // fast shutdown enables
  localparam logic [7:0] ADDR_CURRENT_LIMIT_FAULT_COUNTER     = 8'h1c; // current-limit counter
  localparam logic [7:0] ADDR_PRIO_LO  = 8'h27; // priority, ch 1-4
  localparam logic [7:0] ADDR_PRIO_HI  = 8'h28; // priority, ch 5-8
  localparam logic [7:0] ADDR_CUT_EN   = 8'h2d; // four-pair cut enables
  localparam logic [7:0] ADDR_FW_REV   = 8'h41; // firmware revision
  localparam logic [7:0] ADDR_MEM_CTL  = 8'h60; // memory control
  // field positions
  localparam int SUP_MEMFLT_BIT = 0;
  localparam int SUP_POWER_SUPPLY_UNDERVOLTAGE_FLAG_BIT   = 4;
  localparam int SUP_DIGITAL_SUPPLY_WARNING_FLAG_BIT  = 5;
  localparam int SUP_DIGITAL_SUPPLY_UNDERVOLTAGE_FLAG_BIT   = 6;
  localparam int SUP_TSD_BIT    = 7;
  localparam int FLT_SHDN_BIT   = 1;
  localparam int FLT_CUT_LSB    = 4;
  localparam int PRIO_MODE_BIT  = 7;
  localparam int MEM_RUN_BIT    = 0;
  localparam int MEM_PAR_BIT    = 1;
  localparam int MEM_IMG_BIT    = 2;
  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] MEM_CTL_RST = 8'h00;
  localparam logic [7:0] SAFE_FW_REV = 8'hff; // revision shown in safe mode
  localparam logic [7:0] FW_REV_VAL  = 8'h5a; // arbitrary revision value
  // safe-mode states
  typedef enum logic {PFS_RUN, PFS_SAFE} pfs_mode_t;
endpackage

//--- rtl/pfs_status.sv
// module: supply/fault status, shutdown events, power cut, safe mode
// and discovery registers of an eight-channel power controller.
// assumes a command decoder outside turns bus traffic into the
// reg_* strobes; analog conditions arrive as asynchronous levels.
`timescale 1ns/1ps
module pfs_status
  import pfs_pkg::*;
#(
  parameter int NCH  = 8, // power channels
  parameter int NPRT = 4, // four-pair ports
  parameter int NDSC = 3, // discovery registers
  parameter int NEV  = 4  // channels with detection event bits
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,       // power-on reset
  input  wire logic              reset_pin_b_in, // device reset pin
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_rd_in,
  input  wire logic              reg_cor_in,     // read clears
  output logic      [7:0]        reg_rdata_out,
  input  wire logic              fast_shutdown_pin_in,
  input  wire logic [2:0]        priority_code_in,
  input  wire logic              tsd_cond_in,
  input  wire logic              digital_supply_undervoltage_flag_cond_in,
  input  wire logic              digital_supply_warning_flag_cond_in,
  input  wire logic              power_supply_undervoltage_flag_cond_in,
  input  wire logic              vpwr_above_30_in,
  input  wire logic              vpwr_lockout_in,
  input  wire logic              mem_error_in,   // parity error seen
  input  wire logic [NCH-1:0]    ch_powered_in,
  input  wire logic [NEV-1:0]    class_done_in,
  input  wire logic [NEV-1:0]    det_done_in,
  input  wire logic [4*NDSC-1:0] class_code_in,
  input  wire logic [4*NDSC-1:0] det_code_in,
  input  wire logic [NDSC-1:0]   ch_off_in,
  input  wire logic [NPRT-1:0]   cut_over_in,    // summed overload
  input  wire logic              ilim_event_in,
  output logic      [NCH-1:0]    power_on_out,
  output logic      [NCH-1:0]    ch_force_off_out,
  output logic      [NPRT-1:0]   port_cut_off_out,
  output logic                   safe_mode_out,
  output logic                   mem_run_en_out
);
  localparam int CW = $clog2(OVLD_CYC + 1);
  localparam logic [CW-1:0] OVLD_MAX = CW'(OVLD_CYC);

  // synchronised pins and analog levels
  logic       pin_b_s, fs_s, tsd_s, digital_supply_undervoltage_flag_s, digital_supply_warning_flag_s, power_supply_undervoltage_flag_s;
  logic       above_s, lock_s;
  logic [2:0] code_s;

  pfs_sync3 #(
    .W       (11),
    .RST_VAL (11'h400) // reset pin reads released
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     ({reset_pin_b_in, fast_shutdown_pin_in,
                  priority_code_in, tsd_cond_in, digital_supply_undervoltage_flag_cond_in,
                  digital_supply_warning_flag_cond_in, power_supply_undervoltage_flag_cond_in, vpwr_above_30_in,
                  vpwr_lockout_in}),
    .sync_out   ({pin_b_s, fs_s, code_s, tsd_s, digital_supply_undervoltage_flag_s, digital_supply_warning_flag_s,
                  power_supply_undervoltage_flag_s, above_s, lock_s})
  );

  // register state
  logic [7:0]      mem_ctl_reg;       // run, parity, image loaded
  logic            memflt_reg;        // memory_fault_flag
  logic            tsd_reg, digital_supply_undervoltage_flag_reg, digital_supply_warning_flag_reg, power_supply_undervoltage_flag_reg;
  logic            prio_mode_reg;     // priority_mode_select
  logic [NCH-1:0]  fs_en_reg;         // fast shutdown enables
  logic [7:0]      prio_lo_reg;       // channel_priority_setting
  logic [7:0]      prio_hi_reg;
  logic [NPRT-1:0] cut_en_reg;        // four_pair_cut_enable
  logic            shdn_evt_reg;      // shutdown_event_flag
  logic [NPRT-1:0] cut_flt_reg;       // power_cut_fault_bit
  logic [NEV-1:0]  cls_evt_reg;       // class_complete_event
  logic [NEV-1:0]  det_evt_reg;       // detect_complete_event
  logic [7:0]      current_limit_fault_counter_reg;          // current_limit_fault_counter
  logic [7:0]      disc_reg [NDSC];   // discovery bytes
  logic [CW-1:0]   ovld_cnt [NPRT];   // summed cut timers
  pfs_mode_t       mode_reg;

  // shared reset terms: the pin spares the supply flags
  wire soft_rst = !rst_b_in || !pin_b_s;

  // command decode
  wire wr_mem  = reg_wr_in && (reg_addr_in == ADDR_MEM_CTL);
  wire wr_pwon = reg_wr_in && (reg_addr_in == ADDR_PWR_ON);
  wire cor_any = reg_rd_in && reg_cor_in;
  wire cor_sup = cor_any && (reg_addr_in == ADDR_SUP_EVT);
  wire cor_flt = cor_any && (reg_addr_in == ADDR_FLT_EVT);
  wire cor_det = cor_any && (reg_addr_in == ADDR_DET_EVT);
  wire in_safe = (mode_reg == PFS_SAFE);

  // fault monitoring gated by parity enable and loaded image
  wire mon_on  = mem_ctl_reg[MEM_PAR_BIT] &&
                 mem_ctl_reg[MEM_IMG_BIT];
  wire mem_flt = mem_error_in && mon_on && !in_safe;
  // host sets run enable again after reload
  wire run_set = wr_mem && reg_wdata_in[MEM_RUN_BIT];

  // power-on commands blocked in safe mode, or under undervoltage unless vpwr_above_30_in
  wire pwon_ok = !(power_supply_undervoltage_flag_reg && !above_s) && !in_safe;

  // shutdown event, both priority modes
  logic [NCH-1:0] prio_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_prio
      wire [7:0] pr = (gi < 4) ? prio_lo_reg : prio_hi_reg;
      wire [2:0] ps = pr[(gi % 4 < 2 ? 0 : 4) +: 3] ;
      wire [2:0] pc = (gi % 2 == 0) ? ps : pr[(gi%4<2?4:0)+:3];
      assign prio_hit[gi] = (code_s >= pc);
    end
  endgenerate
  wire shdn_1b  = !prio_mode_reg && fs_s && |fs_en_reg;
  wire shdn_3b  = prio_mode_reg && fs_s &&
                  |(fs_en_reg & prio_hit);
  wire shdn_set = shdn_1b || shdn_3b;

  // summed cut timers expiring this cycle
  logic [NPRT-1:0] cut_hit;
  generate
    for (gi = 0; gi < NPRT; gi++)
    begin : g_cut
      assign cut_hit[gi] = cut_over_in[gi] &&
                           (ovld_cnt[gi] == OVLD_MAX - CW'(1));
    end
  endgenerate

  // mode machine: enters on fault, leaves on run set or POR
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      mode_reg <= PFS_RUN;
    else
      case (mode_reg)
        PFS_RUN:  if (mem_flt) mode_reg <= PFS_SAFE;
        PFS_SAFE: if (run_set) mode_reg <= PFS_RUN;
        default:  mode_reg <= PFS_RUN;
      endcase
  end

  // memory control: fault clears run enable
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      mem_ctl_reg <= MEM_CTL_RST;
    else if (mem_flt)
      mem_ctl_reg[MEM_RUN_BIT] <= 1'b0;
    else if (wr_mem)
      mem_ctl_reg <= reg_wdata_in & 8'h07;
  end

  // memory fault flag, set wins over clear-on-read
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
      memflt_reg <= 1'b0;
    else if (mem_flt)
      memflt_reg <= 1'b1;
    else if (cor_sup)
      memflt_reg <= 1'b0;
  end

  // supply flags: cleared by POR or clear-on-read only, not by the pin
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      tsd_reg   <= 1'b0;
      digital_supply_undervoltage_flag_reg  <= 1'b0;
      digital_supply_warning_flag_reg <= 1'b0;
      power_supply_undervoltage_flag_reg  <= 1'b0;
    end
    else
    begin
      tsd_reg   <= tsd_s   || (tsd_reg   && !cor_sup);
      digital_supply_undervoltage_flag_reg  <= digital_supply_undervoltage_flag_s  || (digital_supply_undervoltage_flag_reg  && !cor_sup);
      digital_supply_warning_flag_reg <= digital_supply_warning_flag_s || (digital_supply_warning_flag_reg && !cor_sup);
      power_supply_undervoltage_flag_reg  <= power_supply_undervoltage_flag_s  || (power_supply_undervoltage_flag_reg  && !cor_sup);
    end
  end

  // configuration registers, frozen in safe mode
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
    begin
      prio_mode_reg <= 1'b0;
      fs_en_reg     <= '0;
      prio_lo_reg   <= RST_BYTE;
      prio_hi_reg   <= RST_BYTE;
      cut_en_reg    <= '1; // cut protection on by default
    end
    else if (reg_wr_in && !in_safe)
      case (reg_addr_in)
        ADDR_PRIO_CFG: prio_mode_reg <= reg_wdata_in[PRIO_MODE_BIT];
        ADDR_FS_EN:    fs_en_reg     <= reg_wdata_in[NCH-1:0];
        ADDR_PRIO_LO:  prio_lo_reg   <= reg_wdata_in;
        ADDR_PRIO_HI:  prio_hi_reg   <= reg_wdata_in;
        ADDR_CUT_EN:   cut_en_reg    <= reg_wdata_in[NPRT-1:0];
        default:       ;
      endcase
  end

  // shutdown event flag
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
      shdn_evt_reg <= 1'b0;
    else
      shdn_evt_reg <= shdn_set || (shdn_evt_reg && !cor_flt);
  end

  // summed cut timers, fault bits and turn-off
  generate
    for (gi = 0; gi < NPRT; gi++)
    begin : g_cutff
      always_ff @(posedge sys_clk_in)
      begin
        if (soft_rst)
          ovld_cnt[gi] <= '0;
        else if (cor_flt && cut_flt_reg[gi])
          ovld_cnt[gi] <= '0;
        else if (cut_over_in[gi] && ovld_cnt[gi] != OVLD_MAX)
          ovld_cnt[gi] <= ovld_cnt[gi] + CW'(1);
        else if (!cut_over_in[gi])
          ovld_cnt[gi] <= '0;
      end
    end
  endgenerate

  // fault bit set wins; turn-off only with cut enabled
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
    begin
      cut_flt_reg      <= '0;
      port_cut_off_out <= '0;
    end
    else
    begin
      cut_flt_reg      <= cut_hit | (cut_flt_reg & ~{NPRT{cor_flt}});
      port_cut_off_out <= cut_hit & cut_en_reg;
    end
  end

  // current-limit counter, untouched by cut clears
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
      current_limit_fault_counter_reg <= RST_BYTE;
    else if (ilim_event_in && current_limit_fault_counter_reg != 8'hff)
      current_limit_fault_counter_reg <= current_limit_fault_counter_reg + 8'h01;
  end

  // detection events: kept under undervoltage, lost at lockout
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst || lock_s)
    begin
      cls_evt_reg <= '0;
      det_evt_reg <= '0;
    end
    else
    begin
      cls_evt_reg <= class_done_in |
                     (cls_evt_reg & ~{NEV{cor_det}});
      det_evt_reg <= det_done_in |
                     (det_evt_reg & ~{NEV{cor_det}});
    end
  end

  // discovery bytes: class high nibble, detect low nibble
  generate
    for (gi = 0; gi < NDSC; gi++)
    begin : g_disc
      always_ff @(posedge sys_clk_in)
      begin
        if (soft_rst || ch_off_in[gi])
          disc_reg[gi] <= RST_BYTE;
        else
        begin
          if (class_done_in[gi])
            disc_reg[gi][7:4] <= class_code_in[4*gi +: 4];
          if (det_done_in[gi])
            disc_reg[gi][3:0] <= det_code_in[4*gi +: 4];
        end
      end
    end
  endgenerate

  // power-on pulses and forced-off mask; powered channels untouched
  always_ff @(posedge sys_clk_in)
  begin
    if (soft_rst)
    begin
      power_on_out     <= '0;
      ch_force_off_out <= '0;
    end
    else
    begin
      power_on_out <= (wr_pwon && pwon_ok) ?
                      reg_wdata_in[NCH-1:0] : '0;
      if (mem_flt)
        ch_force_off_out <= ~ch_powered_in;
      else if (run_set)
        ch_force_off_out <= '0;
    end
  end

  // read mux
  wire [7:0] sup_byte = {tsd_reg, digital_supply_undervoltage_flag_reg, digital_supply_warning_flag_reg, power_supply_undervoltage_flag_reg,
                         3'b000, memflt_reg};
  wire [7:0] flt_byte = {cut_flt_reg, 2'b00, shdn_evt_reg, 1'b0};
  wire [7:0] fw_byte  = in_safe ? SAFE_FW_REV : FW_REV_VAL;
  wire [7:0] rd_mux =
    (reg_addr_in == ADDR_SUP_EVT)  ? sup_byte :
    (reg_addr_in == ADDR_FLT_EVT)  ? flt_byte :
    (reg_addr_in == ADDR_DET_EVT)  ? {cls_evt_reg, det_evt_reg} :
    (reg_addr_in == ADDR_DISC1)    ? disc_reg[0] :
    (reg_addr_in == ADDR_DISC2)    ? disc_reg[1] :
    (reg_addr_in == ADDR_DISC3)    ? disc_reg[2] :
    (reg_addr_in == ADDR_PRIO_CFG) ? {prio_mode_reg, 7'h00} :
    (reg_addr_in == ADDR_FS_EN)    ? fs_en_reg :
    (reg_addr_in == ADDR_CURRENT_LIMIT_FAULT_COUNTER)     ? current_limit_fault_counter_reg :
    (reg_addr_in == ADDR_PRIO_LO)  ? prio_lo_reg :
    (reg_addr_in == ADDR_PRIO_HI)  ? prio_hi_reg :
    (reg_addr_in == ADDR_CUT_EN)   ? {4'h0, cut_en_reg} :
    (reg_addr_in == ADDR_FW_REV)   ? fw_byte :
    (reg_addr_in == ADDR_MEM_CTL)  ? mem_ctl_reg : 8'h00;

  // read data held until the next read
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= RST_BYTE;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
  end

  assign safe_mode_out  = in_safe;
  assign mem_run_en_out = mem_ctl_reg[MEM_RUN_BIT];

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_memflt_entry: assert property (
    mem_flt |=> in_safe && memflt_reg && !mem_run_en_out)
    else $error("memory fault did not enter safe mode");
  a_fwrev_safe: assert property (
    in_safe && reg_rd_in && reg_addr_in == ADDR_FW_REV && !run_set
    |=> reg_rdata_out == 8'hff)
    else $error("revision not ff in safe mode");
  a_pwon_block: assert property (
    wr_pwon && power_supply_undervoltage_flag_reg && !above_s |=> power_on_out == '0)
    else $error("power-on passed under undervoltage");
  a_digital_supply_undervoltage_flag_hold: assert property (
    digital_supply_undervoltage_flag_s && cor_sup |=> digital_supply_undervoltage_flag_reg)
    else $error("digital undervoltage flag lost");
  a_evt_lockout: assert property (
    lock_s |=> cls_evt_reg == '0 && det_evt_reg == '0)
    else $error("detection events survive lockout");
  a_shdn_single: assert property (
    !prio_mode_reg && fs_s && |fs_en_reg |=> shdn_evt_reg)
    else $error("single-bit shutdown not flagged");
  a_shdn_multi: assert property (
    prio_mode_reg && fs_s && fs_en_reg[0] &&
    code_s >= prio_lo_reg[2:0] |=> shdn_evt_reg)
    else $error("three-bit shutdown not flagged");
  a_cut_noturn: assert property (
    cut_hit[0] && !cut_en_reg[0] && !soft_rst
    |=> cut_flt_reg[0] && !port_cut_off_out[0])
    else $error("disabled cut turned port off");
  a_cut_clear: assert property (
    cor_flt && cut_flt_reg[0] && !cut_hit[0] && !soft_rst
    |=> !cut_flt_reg[0] && ovld_cnt[0] == '0)
    else $error("cut bit or counter not cleared");
  a_current_limit_fault_counter_keep: assert property (
    cor_flt && !ilim_event_in && !soft_rst |=> $stable(current_limit_fault_counter_reg))
    else $error("cut clear touched limit counter");
  a_flag_exit: assert property (
    in_safe && run_set && memflt_reg |=> !in_safe && memflt_reg)
    else $error("fault flag dropped on safe exit");
  a_parity_gate: assert property (
    !in_safe && !mon_on |=> !in_safe)
    else $error("safe mode entered without monitoring");
  a_disc_off: assert property (
    ch_off_in[0] |=> disc_reg[0] == 8'h00)
    else $error("discovery not cleared on turn-off");
endmodule // pfs_status

//--- rtl/pfs_sync3.sv
// module: three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk_in
`timescale 1ns/1ps
module pfs_sync3 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_reg; // first stage, read only by s2
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;  // stages two and three match

  assign agree = ~(s2_reg ^ s3_reg);

  // shift chain, output moves only once two stages agree
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      s1_reg   <= RST_VAL;
      s2_reg   <= RST_VAL;
      s3_reg   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= (agree & s3_reg) | (~agree & sync_out);
    end
  end
endmodule // pfs_sync3
